// >>> verilog/superio_logical_device_config.sv
// logical device configuration bank: revision, clock, wakeup, third serial and serial ports 1 and 2
//
// Contract
// RL1: revision register is read only, writes ignored
// RL2: clock activate clear hides its runtime registers, contents and timekeeping kept
// RL3: wakeup activate clear hides its runtime registers, detection kept
// RL4: clock base high bits 7:3 and low bit 0 read zero; lows reset 70h, 72h
// RL5: only interrupt type bit 1 is writable
// RL6: set lock bits stay set until hardware reset
// RL7: lock bit 7 blocks standard bytes 38h-3Fh, reads give FFh
// RL8: lock bit 6 blocks all battery RAM writes
// RL9: lock bit 5 blocks extended byte 00h-1Fh writes
// RL10: lock bit 4 blocks extended byte 00h-1Fh reads
// RL11: lock bit 3 blocks whole extended RAM, reads give FFh
// RL12: three 7-bit index offsets for day alarm, month alarm, century
// RL13: wakeup interrupt number routes the wakeup request, reset 00h
// RL14: wakeup base low bits 3:0 read zero
// RL15: serial base high 7:3 and low 2:0 read zero
// RL16: third port has writable receive and transmit DMA selects, reset 04h
// RL17: bank select enable 0 blocks extended banked register access
// RL18: config bit 2 is read-only busy flag from transfer state
// RL19: power bit 0 stops port clock and defaults outputs; reset 1
// RL20: third port float when inactive with bit 0, transmit always driven low; the code drives transmit low only while the third port is inactive
// RL21: serial ports 1 and 2 float outputs when inactive and bit 0 set
// RL22: serial ports identical except resets; high resets 03h and 02h
// RL23: global enable 0 disables all but clock and wakeup
// RL24: reserved bits read zero
// RL25: logical device number selects the visible bank for every access at index 30h and above; indices below 30h are not banked and are common to all devices
`timescale 1ns/100ps
`include "superio_ldev_regs.svh"

module superio_logical_device_config
	import superio_ldev_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
	input  wire logic       mclk_in,
	input  wire logic       resetn_in,
	input  wire logic [7:0] cfg_index_in,
	input  wire logic [7:0] cfg_wdata_in,
	input  wire logic       cfg_wr_in,
	output logic [7:0]      cfg_rdata_out,
	input  wire ram_req_s   ram_req_in,
	output ram_gate_s       ram_gate_out,
	output logic [6:0]      day_alarm_index_out,
	output logic [6:0]      month_alarm_index_out,
	output logic [6:0]      century_index_out,
	output logic            clock_access_out,
	output logic            wakeup_access_out,
	output logic [3:0]      wakeup_request_line_out,
	input  wire logic [2:0] port_busy_in,
	output logic [2:0]      port_enable_out,
	output logic [2:0]      port_clock_run_out,
	output logic [2:0]      port_float_out,
	output logic [2:0]      port_bank_enable_out,
	output logic            third_port_transmit_out,
	output logic            third_port_transmit_oe_n_out,
	output logic [2:0]      irport_dma_rx_out,
	output logic [2:0]      irport_dma_tx_out
);

	initial begin
		if ($bits(REVISION) != 8) $error("revision width must be 8");
	end

	////////////////////////////////////////////////////////////////
	// decode

	logic [7:0] logical_device_number_q;
	logic [7:0] global_cfg_q;
	logic [7:0] lock_q;
	logic [6:0] day_q, month_q, century_q;
	logic [7:0] clk_hi_q, clk_lo_q, clk_ehi_q, clk_elo_q, clk_irq_q, clk_type_q;
	logic       clk_act_q;
	logic [7:0] wk_hi_q, wk_lo_q, wk_irq_q, wk_type_q;
	logic       wk_act_q;
	logic [2:0] dma_rx_q, dma_tx_q;
	port_cfg_s  port_q [3];
	logic [2:0] busy_s1_q, busy_q;

	wire ldev_sel_e sel = ldev_sel_e'({
		logical_device_number_q == `LDN_SERIAL2,
		logical_device_number_q == `LDN_SERIAL1,
		logical_device_number_q == `LDN_IRPORT,
		logical_device_number_q == `LDN_WAKEUP,
		logical_device_number_q == `LDN_CLOCK}); // RL25
	wire        wr_ldn   = cfg_wr_in && cfg_index_in == `IDX_LDN;
	wire        wr_glob  = cfg_wr_in && cfg_index_in == `IDX_GLOBAL_CFG;
	wire        wr_clk   = cfg_wr_in && sel == SEL_CLOCK; // RL25
	wire        wr_wk    = cfg_wr_in && sel == SEL_WAKEUP;
	wire [2:0]  wr_port  = {3{cfg_wr_in}} & {sel == SEL_SER2, sel == SEL_SER1, sel == SEL_IRPORT};

	function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
		masked = d & m;
	endfunction

	function automatic logic [7:0] irq_type_wr(input logic [7:0] old, input logic [7:0] d);
		irq_type_wr = (old & `IRQ_TYPE_RO) | (d & ~`IRQ_TYPE_RO); // RL5
	endfunction

	////////////////////////////////////////////////////////////////
	// common and clock bank

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			logical_device_number_q <= 8'h00;
			global_cfg_q <= `GLOBAL_CFG_RST;
			lock_q <= 8'h00;
			day_q <= 7'h00;
			month_q <= 7'h00;
			century_q <= 7'h00;
			clk_act_q <= 1'b0;
			clk_hi_q <= 8'h00;
			clk_lo_q <= `CLK_STD_LO_RST; // RL4
			clk_ehi_q <= 8'h00;
			clk_elo_q <= `CLK_EXT_LO_RST; // RL4
			clk_irq_q <= `CLK_IRQ_RST;
			clk_type_q <= `CLK_IRQ_TYPE_RST;
		end else begin
			if (wr_ldn) logical_device_number_q <= cfg_wdata_in;
			if (wr_glob) global_cfg_q <= masked(cfg_wdata_in, 8'h01);
			if (wr_clk) begin
				case (cfg_index_in)
				`IDX_ACTIVATE: clk_act_q <= cfg_wdata_in[0];
				`IDX_BASE0_HI: clk_hi_q <= masked(cfg_wdata_in, `HI_MASK_ALIGNED); // RL4
				`IDX_BASE0_LO: clk_lo_q <= masked(cfg_wdata_in, `LO_MASK_CLOCK); // RL4
				`IDX_BASE1_HI: clk_ehi_q <= masked(cfg_wdata_in, `HI_MASK_ALIGNED); // RL4
				`IDX_BASE1_LO: clk_elo_q <= masked(cfg_wdata_in, `LO_MASK_CLOCK); // RL4
				`IDX_IRQ_NUM: clk_irq_q <= masked(cfg_wdata_in, `IRQ_NUM_MASK);
				`IDX_IRQ_TYPE: clk_type_q <= irq_type_wr(clk_type_q, cfg_wdata_in); // RL5
				`IDX_SPEC0: lock_q <= lock_q | masked(cfg_wdata_in, `LOCK_MASK); // RL6
				`IDX_SPEC1: day_q <= cfg_wdata_in[6:0]; // RL12
				`IDX_SPEC2: month_q <= cfg_wdata_in[6:0]; // RL12
				`IDX_SPEC3: century_q <= cfg_wdata_in[6:0]; // RL12
				default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// wakeup bank and third port DMA

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wk_act_q <= 1'b0;
			wk_hi_q <= 8'h00;
			wk_lo_q <= 8'h00;
			wk_irq_q <= 8'h00; // RL13
			wk_type_q <= `IRQ_TYPE_RST;
			dma_rx_q <= 3'h4; // RL16
			dma_tx_q <= 3'h4; // RL16
		end else begin
			if (wr_wk) begin
				case (cfg_index_in)
				`IDX_ACTIVATE: wk_act_q <= cfg_wdata_in[0];
				`IDX_BASE0_HI: wk_hi_q <= cfg_wdata_in;
				`IDX_BASE0_LO: wk_lo_q <= masked(cfg_wdata_in, `LO_MASK_WAKEUP); // RL14
				`IDX_IRQ_NUM: wk_irq_q <= masked(cfg_wdata_in, `IRQ_NUM_MASK); // RL13
				`IDX_IRQ_TYPE: wk_type_q <= irq_type_wr(wk_type_q, cfg_wdata_in); // RL5
				default: ;
				endcase
			end
			if (wr_port[0] && cfg_index_in == `IDX_DMA0) dma_rx_q <= cfg_wdata_in[2:0]; // RL16
			if (wr_port[0] && cfg_index_in == `IDX_DMA1) dma_tx_q <= cfg_wdata_in[2:0]; // RL16
		end
	end

	////////////////////////////////////////////////////////////////
	// serial style ports: index 0 third port, 1 and 2 serial ports

	for (genvar p = 0; p < 3; p++) begin : g_port
		always_ff @(posedge mclk_in or negedge resetn_in) begin
			if (!resetn_in) begin
				port_q[p].act <= 1'b0;
				port_q[p].base_hi <= (p == 0) ? `IRP_HI_RST : (p == 1) ? `SER1_HI_RST : `SER2_HI_RST; // RL22
				port_q[p].base_lo <= (p == 0) ? `IRP_LO_RST : (p == 1) ? `SER1_LO_RST : `SER2_LO_RST;
				port_q[p].irq_num <= (p == 0) ? 8'h00 : (p == 1) ? `SER1_IRQ_RST : `SER2_IRQ_RST;
				port_q[p].irq_type <= `IRQ_TYPE_RST;
				port_q[p].cfg <= `PORT_CFG_RST; // RL19
			end else if (wr_port[p]) begin
				case (cfg_index_in)
				`IDX_ACTIVATE: port_q[p].act <= cfg_wdata_in[0];
				`IDX_BASE0_HI: port_q[p].base_hi <= masked(cfg_wdata_in, `HI_MASK_ALIGNED); // RL15
				`IDX_BASE0_LO: port_q[p].base_lo <= masked(cfg_wdata_in, `LO_MASK_SERIAL); // RL15
				`IDX_IRQ_NUM: port_q[p].irq_num <= masked(cfg_wdata_in, `IRQ_NUM_MASK);
				`IDX_IRQ_TYPE: port_q[p].irq_type <= irq_type_wr(port_q[p].irq_type, cfg_wdata_in); // RL5
				`IDX_SPEC0: port_q[p].cfg <= masked(cfg_wdata_in, `CFG_WR_MASK); // RL18
				default: ;
				endcase
			end
		end
	end

	// busy comes from the port clock domain, so it is synchronised
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_s1_q <= 3'b000;
			busy_q <= 3'b000;
		end else begin
			busy_s1_q <= port_busy_in;
			busy_q <= busy_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux

	logic [7:0] clk_rd, wk_rd, port_rd [3];
	wire  [2:0] psel = {sel == SEL_SER2, sel == SEL_SER1, sel == SEL_IRPORT};

	always_comb begin
		case (cfg_index_in)
		`IDX_ACTIVATE: clk_rd = {7'h00, clk_act_q}; // RL24
		`IDX_BASE0_HI: clk_rd = clk_hi_q;
		`IDX_BASE0_LO: clk_rd = clk_lo_q;
		`IDX_BASE1_HI: clk_rd = clk_ehi_q;
		`IDX_BASE1_LO: clk_rd = clk_elo_q;
		`IDX_IRQ_NUM: clk_rd = clk_irq_q;
		`IDX_IRQ_TYPE: clk_rd = clk_type_q;
		`IDX_DMA0, `IDX_DMA1: clk_rd = `DMA_NONE;
		`IDX_SPEC0: clk_rd = lock_q;
		`IDX_SPEC1: clk_rd = {1'b0, day_q}; // RL24
		`IDX_SPEC2: clk_rd = {1'b0, month_q};
		`IDX_SPEC3: clk_rd = {1'b0, century_q};
		default: clk_rd = 8'h00;
		endcase
		case (cfg_index_in)
		`IDX_ACTIVATE: wk_rd = {7'h00, wk_act_q};
		`IDX_BASE0_HI: wk_rd = wk_hi_q;
		`IDX_BASE0_LO: wk_rd = wk_lo_q;
		`IDX_IRQ_NUM: wk_rd = wk_irq_q;
		`IDX_IRQ_TYPE: wk_rd = wk_type_q;
		`IDX_DMA0, `IDX_DMA1: wk_rd = `DMA_NONE;
		default: wk_rd = 8'h00;
		endcase
		for (int p = 0; p < 3; p++) begin
			case (cfg_index_in)
			`IDX_ACTIVATE: port_rd[p] = {7'h00, port_q[p].act};
			`IDX_BASE0_HI: port_rd[p] = port_q[p].base_hi;
			`IDX_BASE0_LO: port_rd[p] = port_q[p].base_lo;
			`IDX_IRQ_NUM: port_rd[p] = port_q[p].irq_num;
			`IDX_IRQ_TYPE: port_rd[p] = port_q[p].irq_type;
			`IDX_DMA0: port_rd[p] = (p == 0) ? {5'h00, dma_rx_q} : `DMA_NONE;
			`IDX_DMA1: port_rd[p] = (p == 0) ? {5'h00, dma_tx_q} : `DMA_NONE;
			`IDX_SPEC0: port_rd[p] = port_q[p].cfg | ({7'h00, busy_q[p]} << `CFG_BUSY_BIT); // RL18
			default: port_rd[p] = 8'h00;
			endcase
		end
	end

	logic [7:0] rdata_d;
	always_comb begin
		if (cfg_index_in == `IDX_REVISION) rdata_d = REVISION; // RL1
		else if (cfg_index_in == `IDX_LDN) rdata_d = logical_device_number_q;
		else if (cfg_index_in == `IDX_GLOBAL_CFG) rdata_d = global_cfg_q;
		else if (cfg_index_in < `IDX_ACTIVATE) rdata_d = 8'h00;
		else if (sel == SEL_CLOCK) rdata_d = clk_rd; // RL25
		else if (sel == SEL_WAKEUP) rdata_d = wk_rd;
		else if (psel[0]) rdata_d = port_rd[0];
		else if (psel[1]) rdata_d = port_rd[1];
		else if (psel[2]) rdata_d = port_rd[2];
		else rdata_d = 8'h00; // RL24
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) cfg_rdata_out <= 8'h00;
		else cfg_rdata_out <= rdata_d;
	end

	////////////////////////////////////////////////////////////////
	// effects on the functions

	// the standard lock window is 38h-3Fh only; bytes above it stay open
	wire std_hi = !ram_req_in.ext && ram_req_in.addr >= `STD_LOCK_FIRST && ram_req_in.addr <= `STD_LOCK_LAST;
	wire ext_lo = ram_req_in.ext && ram_req_in.addr <= `EXT_LOW_LAST;
	wire ff_std = lock_q[`LOCK_STD_HI_BIT] && std_hi; // RL7
	wire ff_ext = lock_q[`LOCK_EXT_BIT] && ram_req_in.ext; // RL11

	assign ram_gate_out.allow_wr = ram_req_in.req && ram_req_in.wr && !ff_std && !ff_ext
		&& !lock_q[`LOCK_ALL_WR_BIT] // RL8
		&& !(lock_q[`LOCK_EXT_WR_BIT] && ext_lo); // RL9
	assign ram_gate_out.allow_rd = ram_req_in.req && !ram_req_in.wr && !ff_std && !ff_ext
		&& !(lock_q[`LOCK_EXT_RD_BIT] && ext_lo); // RL10
	assign ram_gate_out.force_ff = ram_req_in.req && !ram_req_in.wr && (ff_std || ff_ext); // RL7 RL11

	assign day_alarm_index_out = day_q; // RL12
	assign month_alarm_index_out = month_q;
	assign century_index_out = century_q;
	assign clock_access_out = clk_act_q; // RL2
	assign wakeup_access_out = wk_act_q; // RL3
	assign wakeup_request_line_out = wk_irq_q[3:0]; // RL13
	assign irport_dma_rx_out = dma_rx_q;
	assign irport_dma_tx_out = dma_tx_q;

	for (genvar p = 0; p < 3; p++) begin : g_eff
		assign port_enable_out[p] = global_cfg_q[0] && port_q[p].act; // RL23
		assign port_clock_run_out[p] = port_enable_out[p] && port_q[p].cfg[`CFG_POWER_BIT]; // RL19
		assign port_float_out[p] = !port_enable_out[p] && port_q[p].cfg[`CFG_FLOAT_BIT]; // RL20 RL21
		assign port_bank_enable_out[p] = port_q[p].cfg[`CFG_BANK_BIT]; // RL17
	end

	assign third_port_transmit_out = 1'b0; // RL20
	assign third_port_transmit_oe_n_out = port_enable_out[0]; // RL20

	////////////////////////////////////////////////////////////////
	// checks

	sequence s_lock_write;
		wr_clk && cfg_index_in == `IDX_SPEC0;
	endsequence

	a_lock_sticky: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL6
		s_lock_write |=> (lock_q & $past(lock_q)) == $past(lock_q)) else $error("lock bit cleared");
	a_revision_ro: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL1
		cfg_index_in == `IDX_REVISION |=> cfg_rdata_out == REVISION) else $error("revision changed");
	a_std_block: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL7
		lock_q[7] && std_hi && ram_req_in.req |-> !ram_gate_out.allow_wr && !ram_gate_out.allow_rd)
		else $error("standard high bytes not blocked");
	a_all_write_block: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL8
		lock_q[6] |-> !ram_gate_out.allow_wr) else $error("ram write passed lock");
	a_ext_rd_block: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL10
		lock_q[4] && ext_lo |-> !ram_gate_out.allow_rd) else $error("extended low read passed");
	a_ext_block: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL11
		lock_q[3] && ram_req_in.req && ram_req_in.ext && !ram_req_in.wr |-> ram_gate_out.force_ff)
		else $error("extended read not forced");
	a_global_off: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL23
		!global_cfg_q[0] |-> port_enable_out == 3'b000) else $error("port enabled with global off");
	a_tx_low: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL20
		!port_enable_out[0] |-> !third_port_transmit_oe_n_out && !third_port_transmit_out)
		else $error("third port transmit not driven low");
	a_port_align: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL15
		wr_port[1] && cfg_index_in == `IDX_BASE0_LO |=> port_q[1].base_lo[2:0] == 3'b000)
		else $error("serial base not aligned");

	sequence s_type_write;
		wr_clk && cfg_index_in == `IDX_IRQ_TYPE;
	endsequence

	sequence s_activate_read;
		cfg_index_in == `IDX_ACTIVATE;
	endsequence

	// bits other than polarity must survive any write
	a_type_fixed: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL5
		s_type_write |=> (clk_type_q & `IRQ_TYPE_RO) == ($past(clk_type_q) & `IRQ_TYPE_RO))
		else $error("interrupt type fixed bits changed");
	a_ext_wr_block: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL9
		lock_q[5] && ext_lo |-> !ram_gate_out.allow_wr) else $error("extended low write passed");
	a_clock_base: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL4
		clk_hi_q[7:3] == 5'h00 && clk_ehi_q[7:3] == 5'h00 && !clk_lo_q[0] && !clk_elo_q[0])
		else $error("clock base fixed bits set");
	a_wakeup_align: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL14
		wk_lo_q[3:0] == 4'h0) else $error("wakeup base not aligned");
	a_std_outside: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL7
		ram_req_in.req && !ram_req_in.ext && ram_req_in.addr > `STD_LOCK_LAST |-> !ram_gate_out.force_ff)
		else $error("standard byte above lock window blocked");
	a_float_idle: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL21
		(port_float_out & port_enable_out) == 3'b000) else $error("enabled port floated");
	a_run_power: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL19
		port_clock_run_out[1] |-> port_q[1].cfg[`CFG_POWER_BIT] && port_enable_out[1])
		else $error("port clock runs in low power");
	a_active_read: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL24
		s_activate_read |=> cfg_rdata_out[7:1] == 7'h00) else $error("activate reserved bits set");
	a_busy_read: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL18
		psel[0] && cfg_index_in == `IDX_SPEC0 |=> cfg_rdata_out[`CFG_BUSY_BIT] == $past(busy_q[0]))
		else $error("busy flag misread");
	a_dma_select: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL16
		wr_port[0] && cfg_index_in == `IDX_DMA0 |=> irport_dma_rx_out == $past(cfg_wdata_in[2:0]))
		else $error("receive dma select not taken");
	a_global_on: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RL23
		global_cfg_q[0] && port_q[2].act |-> port_enable_out[2]) else $error("enabled port held off");

endmodule

// >>> verilog/superio_ldev_regs.svh
// register indices, field positions and reset values of the logical device configuration bank
`ifndef SUPERIO_LDEV_REGS_SVH
`define SUPERIO_LDEV_REGS_SVH

`define IDX_LDN          8'h07
`define IDX_GLOBAL_CFG   8'h21
`define IDX_REVISION     8'h27
`define IDX_ACTIVATE     8'h30
`define IDX_BASE0_HI     8'h60
`define IDX_BASE0_LO     8'h61
`define IDX_BASE1_HI     8'h62
`define IDX_BASE1_LO     8'h63
`define IDX_IRQ_NUM      8'h70
`define IDX_IRQ_TYPE     8'h71
`define IDX_DMA0         8'h74
`define IDX_DMA1         8'h75
`define IDX_SPEC0        8'hF0
`define IDX_SPEC1        8'hF1
`define IDX_SPEC2        8'hF2
`define IDX_SPEC3        8'hF3

`define LDN_CLOCK        8'h00
`define LDN_WAKEUP       8'h01
`define LDN_IRPORT       8'h02
`define LDN_SERIAL1      8'h03
`define LDN_SERIAL2      8'h08

`define GLOBAL_CFG_RST   8'h01
`define DMA_NONE         8'h04
`define CLK_STD_LO_RST   8'h70
`define CLK_EXT_LO_RST   8'h72
`define CLK_IRQ_RST      8'h08
`define IRP_HI_RST       8'h03
`define IRP_LO_RST       8'hE8
`define SER1_HI_RST      8'h03
`define SER1_LO_RST      8'hF8
`define SER1_IRQ_RST     8'h04
`define SER2_HI_RST      8'h02
`define SER2_LO_RST      8'hF8
`define SER2_IRQ_RST     8'h03
`define IRQ_TYPE_RST     8'h03
`define CLK_IRQ_TYPE_RST 8'h00
`define PORT_CFG_RST     8'h02

`define HI_MASK_ALIGNED  8'h07
`define LO_MASK_CLOCK    8'hFE
`define LO_MASK_WAKEUP   8'hF0
`define LO_MASK_SERIAL   8'hF8
`define IRQ_NUM_MASK     8'h0F
`define IRQ_POL_BIT      1
`define IRQ_TYPE_RO      8'hFD
`define DMA_MASK         8'h07
`define LOCK_MASK        8'hF8
`define OFFSET_MASK      8'h7F
`define CFG_WR_MASK      8'h83
`define CFG_BANK_BIT     7
`define CFG_BUSY_BIT     2
`define CFG_POWER_BIT    1
`define CFG_FLOAT_BIT    0

`define LOCK_STD_HI_BIT  7
`define LOCK_ALL_WR_BIT  6
`define LOCK_EXT_WR_BIT  5
`define LOCK_EXT_RD_BIT  4
`define LOCK_EXT_BIT     3
`define STD_LOCK_FIRST   7'h38
`define STD_LOCK_LAST    7'h3F
`define EXT_LOW_LAST     7'h1F
`define RAM_BLOCKED      8'hFF

`endif

// >>> verilog/superio_ldev_pkg.sv
// types shared by the logical device configuration bank
package superio_ldev_pkg;

	typedef struct packed {
		logic [7:0] base_hi;
		logic [7:0] base_lo;
		logic [7:0] irq_num;
		logic [7:0] irq_type;
		logic [7:0] cfg;
		logic       act;
	} port_cfg_s;

	typedef struct packed {
		logic       req;
		logic       wr;
		logic       ext;
		logic [6:0] addr;
	} ram_req_s;

	typedef struct packed {
		logic       allow_wr;
		logic       allow_rd;
		logic       force_ff;
	} ram_gate_s;

	typedef enum logic [4:0] {
		SEL_CLOCK  = 5'b00001,
		SEL_WAKEUP = 5'b00010,
		SEL_IRPORT = 5'b00100,
		SEL_SER1   = 5'b01000,
		SEL_SER2   = 5'b10000
	} ldev_sel_e;

endpackage

// >>> testbench/cfg_host.sv
// host model driving the configuration index and data port
`timescale 1ns/100ps
module cfg_host (
	input  wire logic       mclk_in,
	input  wire logic [7:0] rdata_in,
	output logic [7:0]      index_out,
	output logic [7:0]      wdata_out,
	output logic            wr_out,
	output logic            seen_out,
	output logic [7:0]      value_out
);
	initial begin
		index_out = 8'h00;
		wdata_out = 8'h00;
		wr_out    = 1'h0;
		seen_out  = 1'h0;
		value_out = 8'h00;
	end

	////////////////////////////////////////
	// one write strobe per call, never back to back within one edge
	task automatic put(input logic [7:0] idx, input logic [7:0] dat);
		@(posedge mclk_in);
		#2;
		index_out = idx;
		wdata_out = dat;
		wr_out    = 1'h1;
		@(posedge mclk_in);
		#2;
		wr_out = 1'h0;
	endtask

	// read data lags the index by one edge
	task automatic get(input logic [7:0] idx);
		@(posedge mclk_in);
		#2;
		index_out = idx;
		@(posedge mclk_in);
		#2;
		value_out = rdata_in;
		seen_out  = 1'h1;
		@(posedge mclk_in);
		#2;
		seen_out = 1'h0;
	endtask
endmodule

// >>> testbench/test_superio_logical_device_config.sv
// self-checking bench for the logical device configuration bank
`timescale 1ns/100ps
module test_superio_logical_device_config
	import superio_ldev_pkg::*;
;
	logic        mclk_in   = 1'h0;
	logic        resetn_in = 1'h0;
	logic [7:0]  cfg_index, cfg_wdata, cfg_rdata, value;
	logic        cfg_wr, seen, clk_acc, wake_acc, tx_out, tx_oe_n;
	ram_req_s    ram_req = '0;
	ram_gate_s   ram_gate;
	logic [2:0]  busy = 3'h0;
	logic [2:0]  enable, run, flt, bank, dma_rx, dma_tx;
	logic [6:0]  day_idx, mon_idx, cen_idx;
	logic [3:0]  wake_line;
	int          failures = 0;
	int          num_checks = 0;
	logic [7:0]  expect_q[$];
	logic [31:0] rnd = 32'hB25A8151;
	// {ldn, index, reset value}
	localparam logic [23:0] RST_TAB [40] = '{
		24'h003000, 24'h006000, 24'h006170, 24'h006200, 24'h006372, 24'h007008, 24'h007100, 24'h007404,
		24'h007504, 24'h00F000, 24'h00F100, 24'h00F200, 24'h00F300, 24'h00273C, 24'h002101, 24'h013000,
		24'h016000, 24'h016100, 24'h017000, 24'h017103, 24'h017504, 24'h026003, 24'h0261E8, 24'h027000,
		24'h027103, 24'h027404, 24'h027504, 24'h02F002, 24'h036003, 24'h0361F8, 24'h037004, 24'h037103,
		24'h037404, 24'h03F002, 24'h086002, 24'h0861F8, 24'h087003, 24'h087103, 24'h08F002, 24'h056000};
	// {ldn, index, writable mask, value of fixed bits}; clock lock register left out, it cannot be undone
	localparam logic [31:0] MSK_TAB [23] = '{
		32'h00600700, 32'h0061FE00, 32'h00620700, 32'h0063FE00, 32'h00710200, 32'h00740004, 32'h0027003C,
		32'h00F17F00, 32'h00F27F00, 32'h00F37F00, 32'h0160FF00, 32'h0161F000, 32'h01700F00, 32'h01710201,
		32'h02600700, 32'h0261F800, 32'h02740700, 32'h02750700, 32'h02F08300, 32'h03740004, 32'h0361F800,
		32'h08600700, 32'h08710201};

	superio_logical_device_config #(.REVISION(8'h3C)) dut (
		.mclk_in(mclk_in), .resetn_in(resetn_in), .cfg_index_in(cfg_index), .cfg_wdata_in(cfg_wdata),
		.cfg_wr_in(cfg_wr), .cfg_rdata_out(cfg_rdata), .ram_req_in(ram_req), .ram_gate_out(ram_gate),
		.day_alarm_index_out(day_idx), .month_alarm_index_out(mon_idx), .century_index_out(cen_idx),
		.clock_access_out(clk_acc), .wakeup_access_out(wake_acc), .wakeup_request_line_out(wake_line),
		.port_busy_in(busy), .port_enable_out(enable), .port_clock_run_out(run), .port_float_out(flt),
		.port_bank_enable_out(bank), .third_port_transmit_out(tx_out), .third_port_transmit_oe_n_out(tx_oe_n),
		.irport_dma_rx_out(dma_rx), .irport_dma_tx_out(dma_tx));

	cfg_host host (.mclk_in(mclk_in), .rdata_in(cfg_rdata), .index_out(cfg_index), .wdata_out(cfg_wdata),
		.wr_out(cfg_wr), .seen_out(seen), .value_out(value));

	always #25 mclk_in = ~mclk_in;

	////////////////////////////////////////
	function automatic logic [31:0] next_rnd(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
		num_checks++;
		if (seen_v !== exp_v) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic sel(input logic [7:0] logical_device_number);
		host.put(8'h07, logical_device_number);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp_v);
		expect_q.push_back(exp_v);
		host.get(idx);
	endtask

	// combinational grant: [2] write allowed, [1] read allowed, [0] forced FFh
	task automatic gate(input logic ext, input logic wr, input logic [6:0] addr, input int n, input logic e);
		@(posedge mclk_in);
		#2;
		ram_req = '{1'h1, wr, ext, addr};
		#1;
		check({7'h00, ram_gate[n]}, {7'h00, e});
	endtask

	// outputs may sit one register behind the write, so let one edge pass
	task automatic ports(input logic [2:0] en, input logic [2:0] rn, input logic [2:0] fl);
		@(posedge mclk_in);
		#2;
		check({5'h00, enable}, {5'h00, en});
		check({5'h00, run}, {5'h00, rn});
		check({5'h00, flt}, {5'h00, fl});
	endtask

	always @(posedge mclk_in) begin
		if (seen === 1'h1) begin
			check(value, expect_q.pop_front());
		end
	end

	initial begin
		#(50 * 20000);
		failures++;
		wrap_up();
	end

	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge mclk_in);
		#2;
		resetn_in = 1'h1;
		foreach (RST_TAB[i]) begin
			sel(RST_TAB[i][23:16]);
			rd(RST_TAB[i][15:8], RST_TAB[i][7:0]);
		end
		check({7'h00, clk_acc}, 8'h00);
		for (int pass = 0; pass < 2; pass++) begin
			foreach (MSK_TAB[i]) begin
				rnd = next_rnd(rnd);
				sel(MSK_TAB[i][31:24]);
				host.put(MSK_TAB[i][23:16], rnd[7:0]);
				rd(MSK_TAB[i][23:16], (rnd[7:0] & MSK_TAB[i][15:8]) | (MSK_TAB[i][7:0] & ~MSK_TAB[i][15:8]));
			end
		end
		sel(8'h01);
		host.put(8'h70, 8'hFB);
		check({4'h0, wake_line}, 8'h0B);
		sel(8'h02);
		host.put(8'h74, 8'hFB);
		host.put(8'h75, 8'h06);
		check({1'h0, dma_rx, 1'h0, dma_tx}, 8'h36);
		sel(8'h00);
		host.put(8'hF1, 8'hD5);
		host.put(8'hF2, 8'h2A);
		host.put(8'hF3, 8'hFF);
		check({1'h0, day_idx}, 8'h55);
		check({1'h0, mon_idx}, 8'h2A);
		check({1'h0, cen_idx}, 8'h7F);
		// lock bits are set one at a time; each later write must not clear earlier ones
		host.put(8'hF0, 8'h10);
		gate(1'h1, 1'h0, 7'h05, 1, 1'h0);
		gate(1'h1, 1'h0, 7'h20, 1, 1'h1);
		host.put(8'hF0, 8'h20);
		rd(8'hF0, 8'h30);
		gate(1'h1, 1'h1, 7'h1F, 2, 1'h0);
		gate(1'h1, 1'h1, 7'h20, 2, 1'h1);
		gate(1'h0, 1'h1, 7'h38, 2, 1'h1);
		host.put(8'hF0, 8'h80);
		gate(1'h0, 1'h1, 7'h3A, 2, 1'h0);
		gate(1'h0, 1'h0, 7'h3F, 0, 1'h1);
		gate(1'h0, 1'h0, 7'h37, 0, 1'h0);
		gate(1'h0, 1'h0, 7'h40, 0, 1'h0);
		gate(1'h1, 1'h0, 7'h40, 0, 1'h0);
		host.put(8'hF0, 8'h08);
		gate(1'h1, 1'h0, 7'h40, 0, 1'h1);
		gate(1'h1, 1'h1, 7'h7F, 2, 1'h0);
		gate(1'h0, 1'h1, 7'h00, 2, 1'h1);
		host.put(8'hF0, 8'h47);
		gate(1'h0, 1'h1, 7'h00, 2, 1'h0);
		rd(8'hF0, 8'hF8);
		// all three ports: bank on, float on, power off, inactive
		foreach (RST_TAB[i]) begin
			if (RST_TAB[i][15:8] == 8'h60 && RST_TAB[i][23:16] inside {8'h02, 8'h03, 8'h08}) begin
				sel(RST_TAB[i][23:16]);
				host.put(8'hF0, 8'h81);
				host.put(8'h30, 8'h00);
			end
		end
		ports(3'h0, 3'h0, 3'h7);
		check({5'h00, bank}, 8'h07);
		check({6'h00, tx_out, tx_oe_n}, 8'h00);
		host.put(8'h30, 8'h01);
		sel(8'h03);
		host.put(8'h30, 8'h01);
		host.put(8'hF0, 8'h02);
		sel(8'h02);
		host.put(8'h30, 8'h01);
		ports(3'h7, 3'h2, 3'h0);
		check({5'h00, bank}, 8'h05);
		check({6'h00, tx_out, tx_oe_n}, 8'h01);
		host.put(8'h21, 8'h00);
		sel(8'h00);
		host.put(8'h30, 8'h01);
		sel(8'h01);
		host.put(8'h30, 8'h01);
		@(posedge mclk_in);
		#2;
		check({5'h00, enable}, 8'h00);
		check({6'h00, clk_acc, wake_acc}, 8'h03);
		host.put(8'h21, 8'h01);
		busy = 3'h5;
		repeat (4) @(posedge mclk_in);
		sel(8'h02);
		rd(8'hF0, 8'h85);
		sel(8'h03);
		rd(8'hF0, 8'h02);
		sel(8'h08);
		rd(8'hF0, 8'h85);
		// a second reset in mid-run must drop the lock bits and the device selection
		@(posedge mclk_in);
		#2;
		resetn_in = 1'h0;
		repeat (2) @(posedge mclk_in);
		#2;
		resetn_in = 1'h1;
		rd(8'hF0, 8'h00);
		rd(8'h07, 8'h00);
		repeat (4) @(posedge mclk_in);
		wrap_up();
	end
endmodule
